/* key_token_pkg.sv */
package key_token_pkg;

    // Function codes
    localparam logic [7:0] fn_write_pad    = 8'h96;
    localparam logic [7:0] fn_read_pad     = 8'h69;
    localparam logic [7:0] fn_copy_pad     = 8'h3c;
    localparam logic [7:0] fn_read_subkey  = 8'h66;
    localparam logic [7:0] fn_write_passwd = 8'h5a;
    localparam logic [7:0] fn_write_subkey = 8'h99;

    // Address byte fields
    localparam int addr_lsb   = 0;
    localparam int addr_width = 6;
    localparam int sel_lsb    = 6;
    localparam int sel_width  = 2;

    // Sizes
    localparam int pad_bytes     = 64;
    localparam int part_count    = 3;
    localparam int part_bytes    = 48;
    localparam int field_bytes   = 8;
    localparam int rom_bits      = 64;
    localparam int crc_data_bits = 56;

    // Identity and random source reset values
    localparam logic [7:0]  crc_init      = 8'h00;
    localparam logic [7:0]  family_dflt   = 8'h5c;
    localparam logic [47:0] serial_dflt   = 48'h0000_0000_0001;
    localparam logic [7:0]  lfsr_seed     = 8'ha5;

    typedef enum logic [3:0] {
        st_idle,
        st_func,
        st_addr,
        st_check,
        st_run,
        st_pass,
        st_data,
        st_halt
    } phase_e;

    // One bit of the identity checksum, x^8 + x^5 + x^4 + 1, shifted right
    function automatic logic [7:0] crc_step(input logic [7:0] crc, input logic bit_in);
        logic fb;
        fb = crc[0] ^ bit_in;
        crc_step = {fb, crc[7:1]} ^ {1'b0, 1'b0, 1'b0, 1'b0, fb, fb, 1'b0, 1'b0};
    endfunction : crc_step

endpackage : key_token_pkg

/* key_token_front.sv */
`timescale 1ns/1ps
// What this block does
// - Holds 64-bit identity: family byte, 48-bit serial, checksum over first 56 bits.
// - Checksum uses shift register with XOR feedback, polynomial x^8+x^5+x^4+1.
// - Checksum starts zero; family bits LSB first, then serial, result after 56th.
// - Every byte on the bus moves least significant bit first.
// - Memory commands are taken only after a ROM selection command succeeded.
// - A memory command is function byte, address byte, check byte, in order.
// - Address low 6 bits give start address, upper 2 bits select the subkey.
// - Decode scratchpad write 96h, read 69h and copy to subkey.
// - Decode subkey read 66h, password write 5ah and subkey data write.
// - Three partitions of 384 bits, each with own identifier and password.
// - Secure data is reachable only with the matching partition password.
// - A 64-byte scratchpad is read and written with no password.
// - Scratchpad write stores from start address, increments, until end or reset.
// - Copy with wrong destination password is abandoned, storage untouched.
// - Subkey read with wrong password sends random data.
// - Password write with mismatched identifier ends without erasing anything.
module key_token_front
    import key_token_pkg::*;
#(
    parameter logic [7:0]  family_code = family_dflt,  // Arbitrary value
    parameter logic [47:0] serial_code = serial_dflt   // Arbitrary value
)(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    // Bus events from the slot layer
    input  wire logic        bus_reset,
    input  wire logic        rom_selected,
    input  wire logic        bit_valid,
    input  wire logic        bit_in,
    input  wire logic        bit_req,
    // Bit sent back on a read slot
    output logic             bit_out,
    output logic             bit_out_valid,
    // Identity code and command state
    output logic [63:0]      rom_code,
    output logic [7:0]       cmd_func,
    output logic [7:0]       cmd_addr,
    output logic             cmd_active,
    output logic             cmd_abort
);

    phase_e      phase;
    logic [7:0]  shift;
    logic [2:0]  bit_cnt;
    logic [7:0]  crc;
    logic [5:0]  crc_cnt;
    logic [7:0]  lfsr;
    logic [5:0]  ptr;
    logic [7:0]  pass_match;
    logic        pass_ok;
    logic [7:0]  pad [pad_bytes];
    logic [7:0]  secure [part_count][part_bytes];
    logic [7:0]  ident [part_count][field_bytes];
    logic [7:0]  passwd [part_count][field_bytes];
    logic [7:0]  tx_byte;
    logic [2:0]  tx_cnt;
    logic        byte_done;
    logic [7:0]  next_byte;
    logic [1:0]  sel;
    logic [7:0]  rd_value;

    // Byte assembly, least significant bit first
    assign next_byte = {bit_in, shift[7:1]};
    assign byte_done = bit_valid && (bit_cnt == 3'd7);
    assign sel       = cmd_addr[sel_lsb +: sel_width];

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b || bus_reset)
        begin
            shift   <= 8'h00;
            bit_cnt <= 3'd0;
        end
        else if (bit_valid)
        begin
            shift   <= next_byte;
            bit_cnt <= bit_cnt + 3'd1;
        end
    end

    // Identity checksum computed at power-up over family then serial bits
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            crc     <= crc_init;
            crc_cnt <= 6'd0;
            rom_code <= 64'h0;
        end
        else if (crc_cnt != 6'(crc_data_bits))
        begin
            crc     <= crc_step(crc, rom_bits_in(crc_cnt));
            crc_cnt <= crc_cnt + 6'd1;
        end
        else
        begin
            rom_code <= {crc, serial_code, family_code};
        end
    end

    function automatic logic rom_bits_in(input logic [5:0] idx);
        logic [55:0] body;
        body = {serial_code, family_code};
        rom_bits_in = body[idx];
    endfunction : rom_bits_in

    // Random source for a failed subkey read
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            lfsr <= lfsr_seed;
        else
            lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    end

    // Command sequencer
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b || bus_reset)
        begin
            phase      <= st_idle;
            cmd_func   <= 8'h00;
            cmd_addr   <= 8'h00;
            cmd_active <= 1'b0;
            cmd_abort  <= 1'b0;
            ptr        <= 6'd0;
            pass_ok    <= 1'b1;
            pass_match <= 8'h00;
        end
        else
        begin
            case (phase)
                st_idle:
                    if (rom_selected)
                        phase <= st_func;
                st_func:
                    if (byte_done)
                    begin
                        cmd_func <= next_byte;
                        phase    <= st_addr;
                    end
                st_addr:
                    if (byte_done)
                    begin
                        cmd_addr <= next_byte;
                        ptr      <= next_byte[addr_lsb +: addr_width];
                        phase    <= st_check;
                    end
                st_check:
                    if (byte_done)
                    begin
                        if (next_byte != ~cmd_addr)
                        begin
                            cmd_abort <= 1'b1;
                            phase     <= st_halt;
                        end
                        else
                        begin
                            cmd_active <= 1'b1;
                            pass_match <= 8'h00;
                            pass_ok    <= 1'b1;
                            case (cmd_func)
                                fn_write_pad, fn_read_pad:
                                    phase <= st_run;
                                fn_copy_pad, fn_read_subkey,
                                fn_write_passwd, fn_write_subkey:
                                    phase <= (sel == 2'd3) ? st_halt : st_pass;
                                default:
                                    phase <= st_halt;
                            endcase
                        end
                    end
                st_pass:
                    // Eight bytes compared against identifier or password
                    if (byte_done)
                    begin
                        if (cmd_func == fn_write_passwd)
                            pass_ok <= pass_ok && (next_byte == ident[sel][pass_match[2:0]]);
                        else
                            pass_ok <= pass_ok && (next_byte == passwd[sel][pass_match[2:0]]);
                        pass_match <= pass_match + 8'd1;
                        if (pass_match == 8'(field_bytes - 1))
                            phase <= st_run;
                    end
                st_run:
                    if ((cmd_func == fn_copy_pad || cmd_func == fn_write_passwd
                         || cmd_func == fn_write_subkey) && !pass_ok)
                    begin
                        cmd_abort <= 1'b1;
                        phase     <= st_halt;
                    end
                    else if (cmd_func == fn_copy_pad)
                        phase <= st_halt;
                    else
                        phase <= st_data;
                st_data:
                    if (byte_done || (tx_cnt == 3'd7 && bit_req))
                    begin
                        if (ptr == 6'(pad_bytes - 1))
                            phase <= st_halt;
                        ptr <= ptr + 6'd1;
                    end
                st_halt:
                    cmd_active <= 1'b0;
                default:
                    phase <= st_idle;
            endcase
        end
    end

    // Scratchpad and secure storage writes
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < pad_bytes; i++)
                pad[i] <= 8'h00;
            for (int p = 0; p < part_count; p++)
            begin
                for (int j = 0; j < part_bytes; j++)
                    secure[p][j] <= 8'h00;
                for (int j = 0; j < field_bytes; j++)
                begin
                    ident[p][j]  <= 8'h00;
                    passwd[p][j] <= 8'h00;
                end
            end
        end
        else if (phase == st_run && cmd_func == fn_copy_pad && pass_ok)
        begin
            for (int j = 0; j < part_bytes; j++)
                secure[sel][j] <= pad[j + 2 * field_bytes];
        end
        else if (phase == st_run && cmd_func == fn_write_passwd && pass_ok)
        begin
            for (int j = 0; j < part_bytes; j++)
                secure[sel][j] <= 8'h00;
        end
        else if (phase == st_data && byte_done)
        begin
            if (cmd_func == fn_write_pad)
                pad[ptr] <= next_byte;
            else if (cmd_func == fn_write_passwd)
            begin
                if (ptr < 6'(field_bytes))
                    ident[sel][ptr[2:0]] <= next_byte;
                else if (ptr < 6'(2 * field_bytes))
                    passwd[sel][ptr[2:0]] <= next_byte;
            end
            else if (cmd_func == fn_write_subkey && ptr >= 6'(2 * field_bytes))
                secure[sel][ptr - 6'(2 * field_bytes)] <= next_byte;
        end
    end

    // Read path, one byte shifted out least significant bit first
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b || bus_reset)
        begin
            tx_byte       <= 8'h00;
            tx_cnt        <= 3'd0;
            bit_out       <= 1'b1;
            bit_out_valid <= 1'b0;
        end
        else
        begin
            bit_out_valid <= 1'b0;
            if (phase == st_data && bit_req)
            begin
                bit_out       <= (tx_cnt == 3'd0) ? rd_value[0] : tx_byte[tx_cnt];
                bit_out_valid <= 1'b1;
                if (tx_cnt == 3'd0)
                    tx_byte <= rd_value;
                tx_cnt <= tx_cnt + 3'd1;
            end
        end
    end

    function automatic logic [7:0] read_value(input logic [5:0] idx);
        read_value = 8'hff;
        if (cmd_func == fn_read_pad)
            read_value = pad[idx];
        else if (cmd_func == fn_read_subkey && idx >= 6'(2 * field_bytes))
            read_value = pass_ok ? secure[sel][idx - 6'(2 * field_bytes)] : lfsr;
    endfunction : read_value

    // Process rather than assign, so storage reads inside the function wake it
    always_comb
    begin
        rd_value = read_value(ptr);
    end

    // Checks
    check_abort_a: assert property (
        @(posedge clk_sys) disable iff (!rst_b || bus_reset)
        (phase == st_check && byte_done && next_byte != ~cmd_addr) |=> cmd_abort)
        else $error("bad check byte not refused");
    select_first_a: assert property (
        @(posedge clk_sys) disable iff (!rst_b || bus_reset)
        (phase == st_idle && !rom_selected) |=> phase == st_idle)
        else $error("command taken without selection");
    pad_store_a: assert property (
        @(posedge clk_sys) disable iff (!rst_b || bus_reset)
        (phase == st_data && cmd_func == fn_write_pad && byte_done)
        |=> pad[$past(ptr)] == $past(next_byte))
        else $error("scratchpad byte not stored");
    copy_guard_a: assert property (
        @(posedge clk_sys) disable iff (!rst_b || bus_reset)
        (phase == st_run && !pass_ok && cmd_func == fn_copy_pad)
        |=> phase == st_halt && cmd_abort && $stable(secure[0][0]))
        else $error("copy with wrong password went on");
    ident_guard_a: assert property (
        @(posedge clk_sys) disable iff (!rst_b || bus_reset)
        (phase == st_run && !pass_ok && cmd_func == fn_write_passwd)
        |=> phase == st_halt && cmd_abort && $stable(ident[0][0]))
        else $error("password write with wrong identifier went on");
    read_answer_a: assert property (
        @(posedge clk_sys) disable iff (!rst_b || bus_reset)
        (phase == st_data && bit_req) |=> bit_out_valid)
        else $error("read slot not answered");
    crc_done_a: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        (crc_cnt == 6'(crc_data_bits)) |=> rom_code[55:0] == {serial_code, family_code})
        else $error("identity code wrong");
    pad_run_c: cover property (@(posedge clk_sys) phase == st_data && cmd_func == fn_write_pad);
    pass_bad_c: cover property (@(posedge clk_sys) phase == st_run && !pass_ok);
    abort_c: cover property (@(posedge clk_sys) cmd_abort);

endmodule : key_token_front

/* key_master_model.sv */
`timescale 1ns/1ps
module key_master_model
(
    // Clock
    input  wire logic clk_sys,
    // Bus events towards the token
    output logic      bus_reset,
    output logic      rom_selected,
    output logic      bit_valid,
    output logic      bit_in,
    output logic      bit_req,
    // Read slot answer
    input  wire logic bit_out,
    input  wire logic bit_out_valid
);
    initial
    begin
        bus_reset = 1'b0;
        rom_selected = 1'b0;
        bit_valid = 1'b0;
        bit_in = 1'b1;
        bit_req = 1'b0;
    end

    task automatic pulse_reset();
        @(posedge clk_sys) bus_reset <= 1'b1;
        @(posedge clk_sys) bus_reset <= 1'b0;
    endtask : pulse_reset

    // Selection always precedes a memory command
    task automatic select_rom();
        @(posedge clk_sys) rom_selected <= 1'b1;
        @(posedge clk_sys) rom_selected <= 1'b0;
    endtask : select_rom

    // Released data line shows the inverse of the last bit
    task automatic send_byte(input logic [7:0] b);
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clk_sys);
            bit_valid <= 1'b1;
            bit_in <= b[i];
            @(posedge clk_sys);
            bit_valid <= 1'b0;
            bit_in <= ~b[i];
        end
    endtask : send_byte

    // Function, address, then complement of address
    task automatic send_cmd(input logic [7:0] f, input logic [7:0] a);
        send_byte(f);
        send_byte(a);
        send_byte(~a);
    endtask : send_cmd

    task automatic read_byte(output logic [7:0] b);
        b = 8'hxx;
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clk_sys) bit_req <= 1'b1;
            @(posedge clk_sys) bit_req <= 1'b0;
            for (int k = 0; k < 4; k++)
            begin
                #1;
                if (bit_out_valid === 1'b1)
                begin
                    b[i] = bit_out;
                    break;
                end
                @(posedge clk_sys);
            end
        end
    endtask : read_byte
endmodule : key_master_model

/* key_token_front_bench.sv */
`timescale 1ns/1ps
module key_token_front_bench;
    import key_token_pkg::*;
    logic        clk_sys;
    logic        rst_b;
    logic        bus_reset;
    logic        rom_selected;
    logic        bit_valid;
    logic        bit_in;
    logic        bit_req;
    logic        bit_out;
    logic        bit_out_valid;
    logic [63:0] rom_code;
    logic [7:0]  cmd_func;
    logic [7:0]  cmd_addr;
    logic        cmd_active;
    logic        cmd_abort;
    int          n_fail;
    int          cmp_count;
    logic [7:0]  rd;
    logic [7:0]  crc;
    logic [63:0] exp_rom;
    logic [7:0]  rows [6][2];

    key_token_front key_token_front_i (
        .clk_sys(clk_sys), .rst_b(rst_b), .bus_reset(bus_reset),
        .rom_selected(rom_selected), .bit_valid(bit_valid), .bit_in(bit_in),
        .bit_req(bit_req), .bit_out(bit_out), .bit_out_valid(bit_out_valid),
        .rom_code(rom_code), .cmd_func(cmd_func), .cmd_addr(cmd_addr),
        .cmd_active(cmd_active), .cmd_abort(cmd_abort)
    );

    key_master_model key_master_model_i (
        .clk_sys(clk_sys), .bus_reset(bus_reset), .rom_selected(rom_selected),
        .bit_valid(bit_valid), .bit_in(bit_in), .bit_req(bit_req),
        .bit_out(bit_out), .bit_out_valid(bit_out_valid)
    );

    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop

    task automatic run_cmd(input logic [7:0] f, input logic [7:0] a);
        key_master_model_i.pulse_reset();
        key_master_model_i.select_rom();
        key_master_model_i.send_cmd(f, a);
    endtask : run_cmd

    task automatic send_run(input logic [7:0] first, input int n, input logic [7:0] step);
        for (int i = 0; i < n; i++)
            key_master_model_i.send_byte(first + 8'(i) * step);
    endtask : send_run

    // Shift-right checksum, feedback taps for x^8 + x^5 + x^4 + 1
    function automatic logic [7:0] crc_over(input logic [63:0] v, input int n);
        logic [7:0] c;
        logic       fb;
        c = 8'h00;
        for (int i = 0; i < n; i++)
        begin
            fb = c[0] ^ v[i];
            c = {fb, c[7:1]} ^ (fb ? 8'h0c : 8'h00);
        end
        return c;
    endfunction : crc_over

    initial
    begin
        #200us;
        n_fail++;
        report_and_stop();
    end

    initial
    begin
        n_fail = 0;
        cmp_count = 0;
        rst_b = 1'b0;
        rows = '{'{8'h96, 8'h05}, '{8'h69, 8'h3f}, '{8'h3c, 8'h40},
                 '{8'h66, 8'h50}, '{8'h5a, 8'h80}, '{8'h99, 8'h90}};
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        #1;
        check(bit_out, 1'b1);
        check({cmd_active, cmd_abort, cmd_func}, 10'h000);
        repeat (70) @(posedge clk_sys);
        #1;
        crc = crc_over({8'h00, serial_dflt, family_dflt}, crc_data_bits);
        exp_rom = {crc, serial_dflt, family_dflt};
        check(rom_code, exp_rom);
        check(crc_over(rom_code, rom_bits), 8'h00);
        // Command without a selection is not taken
        key_master_model_i.pulse_reset();
        key_master_model_i.send_cmd(8'h69, 8'h00);
        #1;
        check({cmd_active, cmd_func}, 9'h000);
        for (int r = 0; r < 6; r++)
        begin
            run_cmd(rows[r][0], rows[r][1]);
            #1;
            check({cmd_func, cmd_addr}, {rows[r][0], rows[r][1]});
            check({cmd_active, cmd_abort}, 2'b10);
        end
        // Bad check byte halts until the next bus reset
        key_master_model_i.pulse_reset();
        key_master_model_i.select_rom();
        key_master_model_i.send_byte(fn_read_pad);
        key_master_model_i.send_byte(8'h10);
        key_master_model_i.send_byte(8'h10);
        key_master_model_i.send_byte(8'h55);
        #1;
        check({cmd_active, cmd_abort}, 2'b01);
        key_master_model_i.pulse_reset();
        #1;
        check(cmd_abort, 1'b0);
        // Write near the end, the byte past the end is dropped
        key_master_model_i.select_rom();
        key_master_model_i.send_cmd(fn_write_pad, 8'h3e);
        key_master_model_i.send_byte(8'ha1);
        key_master_model_i.send_byte(8'hb2);
        key_master_model_i.send_byte(8'hc3);
        key_master_model_i.pulse_reset();
        key_master_model_i.select_rom();
        key_master_model_i.send_cmd(fn_read_pad, 8'h3e);
        key_master_model_i.read_byte(rd);
        check(rd, 8'ha1);
        key_master_model_i.read_byte(rd);
        check(rd, 8'hb2);
        // First use: identifier 10..17 and password 18..1f written directly
        run_cmd(fn_write_passwd, 8'h00);
        send_run(8'h00, 8, 8'h00);
        send_run(8'h10, 16, 8'h01);
        // A wrong identifier ends the password write
        run_cmd(fn_write_passwd, 8'h00);
        send_run(8'h00, 8, 8'h00);
        repeat (2) @(posedge clk_sys);
        #1;
        check({cmd_active, cmd_abort}, 2'b01);
        // Scratchpad filled, read back, then copied with the password
        run_cmd(fn_write_pad, 8'h10);
        send_run(8'h40, 48, 8'h01);
        run_cmd(fn_read_pad, 8'h10);
        key_master_model_i.read_byte(rd);
        check(rd, 8'h40);
        run_cmd(fn_copy_pad, 8'h00);
        send_run(8'h18, 8, 8'h01);
        // A copy with a wrong password leaves the subkey alone
        run_cmd(fn_write_pad, 8'h10);
        key_master_model_i.send_byte(8'h99);
        run_cmd(fn_copy_pad, 8'h00);
        send_run(8'h00, 8, 8'h00);
        repeat (2) @(posedge clk_sys);
        #1;
        check({cmd_active, cmd_abort}, 2'b01);
        run_cmd(fn_read_subkey, 8'h10);
        send_run(8'h18, 8, 8'h01);
        key_master_model_i.read_byte(rd);
        check(rd, 8'h40);
        // A wrong read password does not end the read
        run_cmd(fn_read_subkey, 8'h10);
        send_run(8'h00, 8, 8'h00);
        repeat (2) @(posedge clk_sys);
        #1;
        check({cmd_active, cmd_abort}, 2'b10);
        key_master_model_i.pulse_reset();
        report_and_stop();
    end
endmodule : key_token_front_bench
